// ==== sgt_pkg.sv ====
// package for the serial port receive-dma guard timer
// assumes a 32-bit classic wishbone slave with byte addresses
package sgt_pkg;
    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_CTRL_ONE = 8'h04;
    localparam logic [ADR_W-1:0] OFS_INT_ID = 8'h14; // read id, write clear
    localparam logic [ADR_W-1:0] OFS_TIMEOUT = 8'h18;
    localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 8'h1c;
    localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h20;

    // ************************************************************
    // field positions and widths
    // ************************************************************
    localparam int CNT_W = 16;
    localparam int LVL_W = 5;
    localparam int EV_W = 2;
    localparam int BIT_CTRL_OVR = 0;
    localparam int ID_RX_SVC = 0;
    localparam int ID_TX_SVC = 1;
    localparam int ID_OVR = 2;
    localparam int EV_OVR = 0;
    localparam int EV_TMO = 1;

    // ************************************************************
    // reset values and thresholds
    // ************************************************************
    localparam logic [CNT_W-1:0] RST_TIMEOUT = 16'h0000;
    localparam logic [EV_W-1:0] RST_EVENTS = 2'h0;
    localparam logic [LVL_W-1:0] RX_SVC_MAX_LEFT = 5'h03;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage

// ==== sgt_timer_if.sv ====
// interface between register logic and the guard countdown
// assumes both ends run on the same clock
`timescale 1ns/1ns
`default_nettype none
interface sgt_timer_if;
    import sgt_pkg::*;
    logic load;
    logic stop;
    logic [CNT_W-1:0] load_val;
    logic [CNT_W-1:0] count;
    logic running;
    logic expire;
    modport ctl (output load, output stop, output load_val,
                 input count, input running, input expire);
    modport tmr (input load, input stop, input load_val,
                 output count, output running, output expire);
endinterface
`default_nettype wire

// ==== sgt_countdown.sv ====
// guard countdown: loads, decrements once per clock, pulses on zero
// assumes load and stop are single-cycle strobes on clk
`timescale 1ns/1ns
`default_nettype none
module sgt_countdown
    import sgt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    sgt_timer_if.tmr tif
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic running;
        logic expire;
    } sgt_cnt_s;

    sgt_cnt_s s_reg;
    sgt_cnt_s s_next;

    // ************************************************************
    // next state
    // ************************************************************
    // stop wins over load so a register write never races a dma beat
    always_comb begin
        s_next = s_reg;
        s_next.expire = 1'b0;
        if (tif.stop) begin
            s_next.count = tif.load_val;
            s_next.running = 1'b0;
        end else if (tif.load) begin
            s_next.count = tif.load_val;
            s_next.running = (tif.load_val != RST_TIMEOUT);
        end else if (s_reg.running && s_reg.count != RST_TIMEOUT) begin
            s_next.count = s_reg.count - CNT_ONE;
            if (s_reg.count == CNT_ONE) begin
                s_next.expire = 1'b1;
                s_next.running = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{count: RST_TIMEOUT, running: 1'b0, expire: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign tif.count = s_reg.count;
    assign tif.running = s_reg.running;
    assign tif.expire = s_reg.expire;
endmodule
`default_nettype wire

// ==== sgt_top.sv ====
// receive-dma guard timer and overrun clear path of a serial port
// assumes a classic wishbone master and fifo levels synchronous to clk
// Function
// - any write to interrupt clear location clears the overrun interrupt
// - that write leaves every other serial port interrupt unchanged
// - writing zero to overrun bit of control register one clears it
// - clear location is write-only, shares address with identification reads
// - timeout register holds a 16-bit unscaled cycle count
// - timer stays stopped until first receive dma transfer
// - first receive dma transfer loads timer with programmed value
// - loaded nonzero timer decrements by one every clock
// - reaching zero raises the receive timeout interrupt
// - a zero timer never decrements nor raises the interrupt
// - any write to timeout register clears the timeout interrupt
// - reading timeout register returns the running count
// - count sits in bits 15:0, resets to zero, max 65535
// - transmit and receive service requests drive the dma requests
// - receive service request stays low with three or fewer frames
// - overrun interrupt reads as bit 2 of identification register
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sgt_top
    import sgt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_dma_xfer,
    input wire logic rx_overrun_event,
    input wire logic [LVL_W-1:0] rx_fifo_level,
    input wire logic tx_fifo_low,
    output logic rx_service_request,
    output logic tx_service_request,
    output logic rx_overrun_irq,
    output logic rx_timeout_irq,
    output logic irq
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic ovr;
        logic tmo;
        logic [EV_W-1:0] sts;
        logic [EV_W-1:0] msk;
        logic irq;
        logic rx_svc;
        logic tx_svc;
        logic [CNT_W-1:0] prog;
    } sgt_main_s;

    sgt_main_s s_reg;
    sgt_main_s s_next;
    sgt_timer_if tif ();

    logic req;
    logic wr;
    logic rd;
    logic wr_id;
    logic wr_ctrl;
    logic wr_tmo;
    logic ovr_clr;
    logic [CNT_W-1:0] wr_count;
    logic [EV_W-1:0] events;

    // ************************************************************
    // bus decode
    // ************************************************************
    // one request per ack; the ack cycle itself is never taken twice
    assign req = wb_cyc_i && wb_stb_i && !s_reg.ack;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;
    assign wr_id = wr && (wb_adr_i == OFS_INT_ID);
    assign wr_ctrl = wr && (wb_adr_i == OFS_CTRL_ONE);
    assign wr_tmo = wr && (wb_adr_i == OFS_TIMEOUT);

    // low lanes only; upper bits are dropped on write
    assign wr_count = {wb_sel_i[1] ? wb_dat_i[15:8] : s_reg.prog[15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : s_reg.prog[7:0]};

    // any write to the clear location, data ignored
    // a zero in the control bit clears it, a one is ignored
    assign ovr_clr = wr_id || (wr_ctrl && wb_sel_i[0] && !wb_dat_i[BIT_CTRL_OVR]);

    // ************************************************************
    // timer hookup
    // ************************************************************
    // only a dma beat or a register write loads the count; otherwise it only counts down
    // dma beat loads the programmed value
    assign tif.load = rx_dma_xfer;
    // a register write parks the counter on the new value, stopped
    // limitation: a beat in the same cycle as a write is lost, the write wins
    assign tif.stop = wr_tmo;
    assign tif.load_val = wr_tmo ? wr_count : s_reg.prog;

    sgt_countdown u_countdown (
        .clk(clk),
        .rst(rst),
        .tif(tif)
    );

    // status events: bit0 overrun, bit1 timeout expiry
    assign events = {tif.expire, rx_overrun_event};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.ack = req;
        s_next.rdata = 32'h0000_0000;
        // programmed count kept for every later dma load
        if (wr_tmo) begin
            s_next.prog = wr_count;
        end
        // only the overrun flag listens to the clear location
        // set wins over clear so a same-cycle overrun is kept
        s_next.ovr = rx_overrun_event || (s_reg.ovr && !ovr_clr);
        // register write clears; otherwise it holds
        // expiry sets it, and wins over a same-cycle write
        s_next.tmo = tif.expire || (s_reg.tmo && !wr_tmo);
        // sticky status, write one to clear, event wins
        if (wr && wb_adr_i == OFS_IRQ_STATUS && wb_sel_i[0]) begin
            s_next.sts = s_reg.sts & ~wb_dat_i[EV_W-1:0];
        end
        s_next.sts = s_next.sts | events;
        if (wr && wb_adr_i == OFS_IRQ_MASK && wb_sel_i[0]) begin
            s_next.msk = wb_dat_i[EV_W-1:0];
        end
        // next values used so irq tracks status without extra lag
        s_next.irq = |(s_next.sts & s_next.msk);
        // frames at or below the floor are left for software
        // service requests double as dma requests
        s_next.rx_svc = (rx_fifo_level > RX_SVC_MAX_LEFT);
        s_next.tx_svc = tx_fifo_low;
        // read mux; unmapped addresses still ack with zero data
        // writes ack with zero data, so nothing written ever echoes back
        if (rd) begin
            unique case (wb_adr_i)
                OFS_CTRL_ONE: begin
                    s_next.rdata[BIT_CTRL_OVR] = s_reg.ovr;
                end
                OFS_INT_ID: begin
                    s_next.rdata[ID_OVR] = s_reg.ovr;
                    s_next.rdata[ID_TX_SVC] = s_reg.tx_svc;
                    s_next.rdata[ID_RX_SVC] = s_reg.rx_svc;
                end
                OFS_TIMEOUT: begin
                    // live count, not the programmed value
                    s_next.rdata[CNT_W-1:0] = tif.count;
                end
                OFS_IRQ_STATUS: begin
                    s_next.rdata[EV_W-1:0] = s_reg.sts;
                end
                OFS_IRQ_MASK: begin
                    s_next.rdata[EV_W-1:0] = s_reg.msk;
                end
                default: begin
                    s_next.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg <= '{ack: 1'b0, rdata: 32'h0000_0000, ovr: 1'b0,
                       tmo: 1'b0, sts: RST_EVENTS, msk: RST_EVENTS,
                       irq: 1'b0, rx_svc: 1'b0, tx_svc: 1'b0,
                       prog: RST_TIMEOUT};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flops
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;
    assign rx_overrun_irq = s_reg.ovr;
    assign rx_timeout_irq = s_reg.tmo;
    assign irq = s_reg.irq;
    assign rx_service_request = s_reg.rx_svc;
    assign tx_service_request = s_reg.tx_svc;

    // ************************************************************
    // checks
    // ************************************************************
    // helper: has a dma beat been seen since reset
    logic seen_dma;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_dma <= 1'b0;
        end else if (rx_dma_xfer) begin
            seen_dma <= 1'b1;
        end
    end

    // one clock domain, so one default clocking serves every check
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_clear_kills_ovr: assert property (
        (wr_id && !rx_overrun_event) |=> !rx_overrun_irq)
        else $error("clear write left overrun set");

    chk_clear_spares_tmo: assert property (
        (wr_id && !tif.expire && !wr_tmo) |=> $stable(rx_timeout_irq))
        else $error("clear write touched timeout");

    chk_ctrl_zero_clear: assert property (
        (wr_ctrl && wb_sel_i[0] && !wb_dat_i[0] && !rx_overrun_event)
        |=> !rx_overrun_irq)
        else $error("zero write left overrun set");

    chk_id_read_bit: assert property (
        (rd && wb_adr_i == OFS_INT_ID)
        |=> wb_ack_o && wb_dat_o[2] == $past(rx_overrun_irq) && wb_dat_o[31:3] == 29'h0)
        else $error("identification read wrong");

    chk_timer_stopped: assert property (
        (!seen_dma && !rx_dma_xfer && !wr_tmo) |=> $stable(tif.count))
        else $error("timer moved before first dma");

    chk_timer_load: assert property (
        (rx_dma_xfer && !wr_tmo) |=> tif.count == $past(s_reg.prog))
        else $error("dma beat did not load timer");

    chk_timer_decrement: assert property (
        (tif.running && tif.count != 16'h0000 && !rx_dma_xfer && !wr_tmo)
        |=> tif.count == $past(tif.count) - 16'h0001)
        else $error("timer did not step by one");

    chk_zero_expiry: assert property (
        (tif.running && tif.count == 16'h0001 && !rx_dma_xfer && !wr_tmo)
        |=> ##1 rx_timeout_irq)
        else $error("expiry raised no timeout");

    chk_zero_disables: assert property (
        (rx_dma_xfer && !wr_tmo && s_reg.prog == 16'h0000)
        |=> !tif.running ##1 !tif.expire)
        else $error("zero count started timer");

    chk_write_clears_tmo: assert property (
        (wr_tmo && !tif.expire) |=> !rx_timeout_irq)
        else $error("timeout write left interrupt");

    chk_read_count: assert property (
        (rd && wb_adr_i == OFS_TIMEOUT)
        |=> wb_dat_o[15:0] == $past(tif.count) && wb_dat_o[31:16] == 16'h0000)
        else $error("timeout read not live count");

    chk_rx_svc_floor: assert property (
        (rx_fifo_level <= 5'h03) |=> !rx_service_request)
        else $error("service request with few frames");

    chk_tmo_sticky: assert property (
        (rx_timeout_irq && !wr_tmo) |=> rx_timeout_irq)
        else $error("timeout interrupt dropped alone");

    chk_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than a cycle");

    // ************************************************************
    // contract and side-effect checks
    // ************************************************************
    // a taken request is answered on the very next edge
    chk_ack_after_take: assert property (
        req |=> wb_ack_o)
        else $error("request not acknowledged");

    // read data is zero outside the ack cycle of a read
    chk_dat_idle_zero: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");

    chk_clear_spares_svc: assert property (
        wr_id |=> rx_service_request == ($past(rx_fifo_level) > 5'h03)
        && tx_service_request == $past(tx_fifo_low))
        else $error("clear write touched service request");

    chk_clear_spares_sts: assert property (
        wr_id |=> (s_reg.sts & $past(s_reg.sts)) == $past(s_reg.sts))
        else $error("clear write dropped a status bit");

    chk_ctrl_one_kept: assert property (
        (wr_ctrl && wb_sel_i[0] && wb_dat_i[0] && rx_overrun_irq) |=> rx_overrun_irq)
        else $error("one write cleared overrun");

    // nothing written to the clear location ever reads back
    chk_clear_no_retain: assert property (
        wr_id |=> wb_ack_o && wb_dat_o == 32'h0000_0000)
        else $error("clear write returned data");

    chk_count_written: assert property (
        (wr_tmo && wb_sel_i[1:0] == 2'h3) |=> tif.count == $past(wb_dat_i[15:0]))
        else $error("timeout write not kept");

    // a register write parks the counter until the next dma beat
    chk_write_parks: assert property (
        wr_tmo |=> !tif.running)
        else $error("timer ran after write");

    chk_expire_at_zero: assert property (
        tif.expire |-> tif.count == 16'h0000 && !tif.running)
        else $error("expiry away from zero");

    chk_tmo_from_expiry: assert property (
        $rose(rx_timeout_irq) |-> $past(tif.expire))
        else $error("timeout raised without expiry");

    chk_zero_holds: assert property (
        (tif.count == 16'h0000 && !rx_dma_xfer && !wr_tmo)
        |=> tif.count == 16'h0000 && !tif.expire)
        else $error("zero timer moved");

    chk_rx_svc_above: assert property (
        (rx_fifo_level > 5'h03) |=> rx_service_request)
        else $error("no service request with frames");

    chk_tx_svc_follow: assert property (
        tx_fifo_low |=> tx_service_request)
        else $error("transmit request missing");

    // covers for the main scenarios
    cov_icr_write: cover property (wr_id ##1 !rx_overrun_irq);
    cov_timer_expiry: cover property (rx_dma_xfer ##[1:100] tif.expire);
    cov_dma_reload: cover property (rx_dma_xfer ##4 rx_dma_xfer);
    cov_irq_raised: cover property (!irq ##1 irq);
    cov_write_in_run: cover property (tif.running && wr_tmo);
endmodule
`default_nettype wire

// ==== sgt_dma_model.sv ====
// far side model: receive fifo fill level plus the dma engine
// assumes the block raises its service request one clock after the level
`timescale 1ns/1ns
`default_nettype none
module sgt_dma_model
    import sgt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic add,
    input wire logic hand_read,
    input wire logic stall,
    input wire logic rx_service_request,
    output logic [LVL_W-1:0] rx_fifo_level,
    output logic rx_dma_xfer
);
    logic [1:0] gap_reg;

    // dma pulls one frame only while requested
    // the gap lets the lagging request catch up, else we over-pull
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_fifo_level <= '0;
            rx_dma_xfer <= 1'b0;
            gap_reg <= 2'h0;
        end else begin
            rx_dma_xfer <= rx_service_request && !stall && !rx_dma_xfer && gap_reg == 2'h0;
            gap_reg <= rx_dma_xfer ? 2'h2 : (gap_reg != 2'h0 ? gap_reg - 2'h1 : 2'h0);
            rx_fifo_level <= rx_fifo_level + LVL_W'(add) - LVL_W'(rx_dma_xfer)
                - LVL_W'(hand_read);
        end
    end
endmodule
`default_nettype wire

// ==== tb_sgt_top.sv ====
// self-checking bench for the receive-dma guard timer
// assumes the dma model file and the design files are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_sgt_top;
    import sgt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, ovr_ev = 1'b0, tx_low = 1'b0, add = 1'b0, hand = 1'b0, stall = 1'b0;
    logic xfer, rx_req, tx_req, ovr_irq, tmo_irq, irq;
    logic [LVL_W-1:0] level;
    int err_count = 0;
    int total_checks = 0;
    int cyc_cnt = 0;
    int t_ack;

    sgt_top sgt_top_i (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_dma_xfer(xfer),
        .rx_overrun_event(ovr_ev), .rx_fifo_level(level), .tx_fifo_low(tx_low),
        .rx_service_request(rx_req), .tx_service_request(tx_req),
        .rx_overrun_irq(ovr_irq), .rx_timeout_irq(tmo_irq), .irq(irq));
    sgt_dma_model sgt_dma_model_i (.clk(clk), .rst(rst), .add(add), .hand_read(hand),
        .stall(stall), .rx_service_request(rx_req), .rx_fifo_level(level),
        .rx_dma_xfer(xfer));

    // clock and a free cycle count for timing reads
    always #4 clk = ~clk;
    always @(posedge clk) cyc_cnt <= cyc_cnt + 1;

    // ************************************************************
    // helper tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic timeout();
        err_count++;
        $display("Error %0t: wait ran out", $time);
        report_and_stop();
    endtask

    // one classic cycle; held until ack is sampled high
    task automatic wb(input logic [ADR_W-1:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) timeout();
        rdat = dat_o;
        t_ack = cyc_cnt;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // frames in (h=0) or read by hand (h=1), one per clock
    task automatic frames(input int n, input bit h);
        repeat (n) begin
            @(posedge clk);
            add <= !h;
            hand <= h;
        end
        @(posedge clk);
        add <= 1'b0;
        hand <= 1'b0;
    endtask

    task automatic overrun();
        @(posedge clk);
        ovr_ev <= 1'b1;
        @(posedge clk);
        ovr_ev <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int i;
        logic [31:0] v1;
        int t1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        check(rdat, 32'h0);
        wb(OFS_INT_ID, 1'b0, 32'h0);
        check(rdat, 32'h0);
        wb(OFS_TIMEOUT, 1'b1, 32'h0000ffff);
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        check(rdat, 32'h0000ffff);
        // frames wait while dma stalls; timer must stay parked
        wb(OFS_TIMEOUT, 1'b1, 32'h00000040);
        wb(OFS_IRQ_MASK, 1'b1, 32'h2);
        tx_low <= 1'b1;
        stall <= 1'b1;
        frames(6, 1'b0);
        repeat (10) @(posedge clk);
        check(32'(rx_req), 32'h1);
        check(32'(tx_req), 32'h1);
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        check(rdat, 32'h40);
        wb(OFS_INT_ID, 1'b0, 32'h0);
        check(rdat, 32'h3);
        stall <= 1'b0;
        repeat (30) @(posedge clk);
        check(32'(level), 32'h3);
        check(32'(rx_req), 32'h0);
        // two reads of the running count, spaced by known cycles
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        v1 = rdat;
        t1 = t_ack;
        check(32'(v1 <= 32'h40 && v1 != 32'h0), 32'h1);
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        check(v1 - rdat, 32'(t_ack - t1));
        for (i = 0; i < 200 && tmo_irq !== 1'b1; i++) @(posedge clk);
        if (tmo_irq !== 1'b1) timeout();
        check(32'(irq), 32'h1);
        wb(OFS_IRQ_STATUS, 1'b0, 32'h0);
        check(rdat, 32'h2);
        repeat (20) @(posedge clk);
        check(32'(tmo_irq), 32'h1);
        wb(OFS_INT_ID, 1'b1, 32'h0);
        check(32'(tmo_irq), 32'h1);
        frames(3, 1'b1);
        wb(OFS_TIMEOUT, 1'b1, 32'h0);
        @(posedge clk);
        check(32'(tmo_irq), 32'h0);
        wb(OFS_IRQ_STATUS, 1'b1, 32'h2);
        @(posedge clk);
        check(32'(irq), 32'h0);
        // zero count: a beat must not start the timer
        frames(4, 1'b0);
        repeat (80) @(posedge clk);
        check(32'(tmo_irq), 32'h0);
        wb(OFS_TIMEOUT, 1'b0, 32'h0);
        check(rdat, 32'h0);
        frames(3, 1'b1);
        // clear location: any data clears overrun, nothing else
        for (i = 0; i < 2; i++) begin
            overrun();
            check(32'(irq), 32'h0);
            wb(OFS_INT_ID, 1'b0, 32'h0);
            check(rdat, 32'h6);
            wb(OFS_INT_ID, 1'b1, i ? 32'hffffffff : 32'h0);
            @(posedge clk);
            check(32'(ovr_irq), 32'h0);
            wb(OFS_INT_ID, 1'b0, 32'h0);
            check(rdat, 32'h2);
        end
        overrun();
        wb(OFS_CTRL_ONE, 1'b0, 32'h0);
        check(rdat, 32'h1);
        wb(OFS_CTRL_ONE, 1'b1, 32'h1);
        check(32'(ovr_irq), 32'h1);
        wb(OFS_CTRL_ONE, 1'b1, 32'h0);
        @(posedge clk);
        check(32'(ovr_irq), 32'h0);
        wb(8'h40, 1'b0, 32'h0);
        check(rdat, 32'h0);
        // overrun status reaches the pin once unmasked
        wb(OFS_IRQ_MASK, 1'b1, 32'h3);
        @(posedge clk);
        check(32'(irq), 32'h1);
        wb(OFS_IRQ_STATUS, 1'b0, 32'h0);
        check(rdat, 32'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
